// [hw/slfr_pkg.sv]
// constants shared by the serial link fault reporter
package slfr_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int CLK_KHZ        = 25000;
  localparam int TX_PERIOD_US   = 2;
  localparam int TX_PERIOD_CYC  = (TX_PERIOD_US * CLK_KHZ) / 1000;
  localparam int CANCEL_US      = 100;
  localparam int CANCEL_CYC     = (CANCEL_US * CLK_KHZ) / 1000;
  localparam int WDT_US         = 1000;
  localparam int WDT_CYC        = (WDT_US * CLK_KHZ) / 1000;

  // --------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] TXST_OFS   = 8'h08;
  localparam logic [7:0] RXST_OFS   = 8'h0c;
  localparam logic [7:0] FAULT_OFS  = 8'h10;
  localparam logic [7:0] ALARM_OFS  = 8'h14;
  localparam logic [7:0] ISTAT_OFS  = 8'h18;
  localparam logic [7:0] IMASK_OFS  = 8'h1c;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 0;
  localparam int MB_RX_BAD_BIT   = 0;
  localparam int MB_SLV_ERR_BIT  = 1;
  localparam int MB_CANCEL_BIT   = 2;
  localparam int MB_PAR_LO_BIT   = 3;
  localparam int MB_PAR_HI_BIT   = 4;
  localparam int SB_GROUP_W      = 5;
  localparam int SB_BAD_BIT      = 5;
  localparam int SB_OTHER_BIT    = 6;
  localparam int SB_WDT_PAR_BIT  = 7;
  localparam int FAULT_CH_LSB    = 16;
  localparam int FAULT_SUB_BIT   = 18;
  localparam int ALARM_SLOT_LSB  = 16;
  localparam int NCH             = 2;
  localparam int NEV             = 6;

  // slave error kind vector positions
  localparam int KIND_BAD   = 0;
  localparam int KIND_OTHER = 1;
  localparam int KIND_WDTP  = 2;

  // --------------------------------------------------------------------
  // event indices, in priority order, and alarm numbers
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SLFR_EV_LINK, SLFR_EV_WDT, SLFR_EV_OPT,
    SLFR_EV_FBUS, SLFR_EV_MBUS, SLFR_EV_LBUS
  } slfr_ev_e;

  localparam logic [9:0] ALM_SEQ   = 10'h3b6;  // 950
  localparam logic [9:0] ALM_WDT   = 10'h3b7;  // 951
  localparam logic [9:0] ALM_OPT   = 10'h3cc;  // 972
  localparam logic [9:0] ALM_FBUS  = 10'h3ce;  // 974
  localparam logic [9:0] ALM_MBUS  = 10'h3cf;  // 975
  localparam logic [9:0] ALM_LBUS  = 10'h3d0;  // 976
  localparam logic [9:0] ALM_NONE  = 10'h000;

  localparam logic [15:0] PERIOD_RST = 16'(TX_PERIOD_CYC);

endpackage

// [hw/slfr_top.sv]
// serial link master with fault encoding, alarms and wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

// What this block does
// RULE1: slaves send input states periodically; a silent channel is flagged cancelled.
// RULE2: master sends its output states to slaves at a fixed period.
// RULE3: this block always acts as link master; the rest are slaves.
// RULE4: any link or internal parity fault raises alarm 950, with link subcode flag for link errors.
// RULE5: report shows both fault bytes and which link channel failed.
// RULE6: bit 0 of master fault byte: master got invalid data.
// RULE7: bit 1 of master fault byte: a slave reported an error.
// RULE8: bit 2 of master fault byte: link to a slave was cancelled.
// RULE9: bit 3 or 4 of master fault byte: internal parity error.
// RULE10: slave fault byte low five bits hold faulting group plus one.
// RULE11: bit 5 of slave fault byte: slave saw invalid data.
// RULE12: bit 6 of slave fault byte: slave reported another error.
// RULE13: bit 7 of slave fault byte: slave watchdog or parity error.
// RULE14: watchdog timeout of the sequence controller raises alarm 951.
// RULE15: option board error raises alarm 972 and reports its slot.
// RULE16: bus error between main and option board raises alarm 974.
// RULE17: bus error inside the main board raises alarm 975.
// RULE18: local bus error on the main board raises alarm 976.
// RULE19: fault word is master byte high, slave byte low.
module slfr_top #(
  parameter int IN_W       = 32,
  parameter int OUT_W      = 32,
  parameter int CANCEL_LIM = slfr_pkg::CANCEL_CYC,
  parameter int WDT_LIM    = slfr_pkg::WDT_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  int_o,
  // link side, from the on-chip link transceiver
  output logic                  link_master_o,
  output logic                  tx_frame_o,
  output logic      [OUT_W-1:0] tx_state_o,
  input  wire logic [1:0]       rx_valid_i,
  input  wire logic [IN_W-1:0]  rx_state_i,
  input  wire logic [1:0]       rx_bad_i,
  input  wire logic [1:0]       slv_err_i,
  input  wire logic [4:0]       slv_group_i,
  input  wire logic [2:0]       slv_kind_i,
  input  wire logic [1:0]       par_err_i,
  // sequence controller and board events
  input  wire logic             wdt_kick_i,
  input  wire logic             opt_err_i,
  input  wire logic [7:0]       opt_slot_i,
  input  wire logic             fbus_err_i,
  input  wire logic             mbus_err_i,
  input  wire logic             lbus_err_i,
  // alarm report
  output logic                  alarm_valid_o,
  output logic      [9:0]       alarm_code_o,
  output logic                  link_fault_subcode_o,
  output logic      [15:0]      fault_word_o,
  output logic      [1:0]       fault_ch_o,
  output logic      [7:0]       opt_slot_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] bmask(input logic [3:0] sel);
    bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic             ack_r;
  logic [31:0]      dat_r;
  logic             en_r;
  logic [15:0]      period_r;
  logic [15:0]      per_cnt_r;
  logic [OUT_W-1:0] txst_r;
  logic [OUT_W-1:0] tx_out_r;
  logic             tx_frame_r;
  logic [IN_W-1:0]  rxst_r;
  logic [7:0]       mbyte_r;
  logic [7:0]       sbyte_r;
  logic [1:0]       fch_r;
  logic             sub_r;
  logic [9:0]       alarm_r;
  logic             alarm_v_r;
  logic [7:0]       slot_r;
  logic [5:0]       istat_r;
  logic [5:0]       imask_r;
  logic             irq_r;
  logic [31:0]      wdt_cnt_r;
  logic             wdt_hit_r;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // ack is registered, so every access costs one wait state; a strobe
  // held past ack starts a second access, which the master must avoid
  wire        req      = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr       = req & wb_we_i;
  wire [31:0] wmask    = bmask(wb_sel_i);
  wire        wr_ctrl  = wr & hit(wb_adr_i, slfr_pkg::CTRL_OFS);
  wire        wr_per   = wr & hit(wb_adr_i, slfr_pkg::PERIOD_OFS);
  wire        wr_txst  = wr & hit(wb_adr_i, slfr_pkg::TXST_OFS);
  wire        wr_fault = wr & hit(wb_adr_i, slfr_pkg::FAULT_OFS);
  wire        wr_alarm = wr & hit(wb_adr_i, slfr_pkg::ALARM_OFS);
  wire        wr_istat = wr & hit(wb_adr_i, slfr_pkg::ISTAT_OFS);
  wire        wr_imask = wr & hit(wb_adr_i, slfr_pkg::IMASK_OFS);

  wire [31:0] ctrl_nxt  = (32'(en_r) & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] per_nxt   = (32'(period_r) & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] imask_nxt = (32'(imask_r) & ~wmask) | (wb_dat_i & wmask);
  wire [31:0] tx_merge  = (32'(txst_r) & ~wmask) | (wb_dat_i & wmask);
  wire [5:0]  iclr      = wr_istat ? (wb_dat_i[5:0] & wmask[5:0]) : 6'h00;

  wire [31:0] fault_rd = {13'h0000, sub_r, fch_r, mbyte_r, sbyte_r};   // RULE5 RULE19
  wire [31:0] alarm_rd = {8'h00, slot_r, 5'h00, alarm_v_r, alarm_r};

  wire [31:0] rd_data =
      hit(wb_adr_i, slfr_pkg::CTRL_OFS)   ? 32'(en_r)      :
      hit(wb_adr_i, slfr_pkg::PERIOD_OFS) ? 32'(period_r)  :
      hit(wb_adr_i, slfr_pkg::TXST_OFS)   ? 32'(txst_r)    :
      hit(wb_adr_i, slfr_pkg::RXST_OFS)   ? 32'(rxst_r)    :
      hit(wb_adr_i, slfr_pkg::FAULT_OFS)  ? fault_rd       :
      hit(wb_adr_i, slfr_pkg::ALARM_OFS)  ? alarm_rd       :
      hit(wb_adr_i, slfr_pkg::ISTAT_OFS)  ? 32'(istat_r)   :
      hit(wb_adr_i, slfr_pkg::IMASK_OFS)  ? 32'(imask_r)   :
                                            32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      dat_r <= req ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r     <= 1'b0;
      period_r <= slfr_pkg::PERIOD_RST;
      imask_r  <= 6'h00;
    end else begin
      if (wr_ctrl)
        en_r <= ctrl_nxt[slfr_pkg::CTRL_EN_BIT];
      // a zero period would stall the frame timer, so it is held at one
      if (wr_per)
        period_r <= (per_nxt[15:0] == 16'h0000) ? 16'h0001 : per_nxt[15:0];
      if (wr_imask)
        imask_r <= imask_nxt[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // periodic output transfer
  // ----------------------------------------------------------------------
  wire per_done = (per_cnt_r >= period_r - 16'h0001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cnt_r  <= 16'h0000;
      txst_r     <= '0;
      tx_out_r   <= '0;
      tx_frame_r <= 1'b0;
    end else begin
      if (wr_txst)
        txst_r <= tx_merge[OUT_W-1:0];
      tx_frame_r <= en_r & per_done;                           // RULE2
      if (!en_r || per_done)
        per_cnt_r <= 16'h0000;
      else
        per_cnt_r <= per_cnt_r + 16'h0001;
      // states are latched once per frame so a frame never shows a torn word
      if (en_r && per_done)
        tx_out_r <= txst_r;                                    // RULE2
    end
  end

  // ----------------------------------------------------------------------
  // per-channel input watch: a channel that stops answering is cancelled
  // ----------------------------------------------------------------------
  logic [1:0] cancel_ev;

  genvar ch;
  generate
    for (ch = 0; ch < slfr_pkg::NCH; ch++) begin : g_ch
      logic [31:0] silent_r;
      logic        tripped_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          silent_r  <= 32'h0000_0000;
          tripped_r <= 1'b0;
        end else if (!en_r || rx_valid_i[ch]) begin
          silent_r  <= 32'h0000_0000;
          tripped_r <= 1'b0;
        end else if (silent_r >= 32'(CANCEL_LIM - 1)) begin
          tripped_r <= 1'b1;                                   // RULE1 RULE8
        end else begin
          silent_r <= silent_r + 32'h0000_0001;
        end
      end
      assign cancel_ev[ch] = en_r & ~rx_valid_i[ch] & ~tripped_r &
                             (silent_r >= 32'(CANCEL_LIM - 1));
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i)
      rxst_r <= '0;
    else if (en_r && |rx_valid_i)
      rxst_r <= rx_state_i;                                    // RULE1
  end

  // ----------------------------------------------------------------------
  // fault byte encoding
  // ----------------------------------------------------------------------
  wire [1:0] bad_ev  = rx_bad_i  & {2{en_r}};
  wire [1:0] slv_ev  = slv_err_i & {2{en_r}};
  wire [1:0] ch_ev   = bad_ev | slv_ev | cancel_ev;
  wire       link_ev = |ch_ev;

  wire [7:0] mb_set;
  assign mb_set[slfr_pkg::MB_RX_BAD_BIT]  = |bad_ev;           // RULE6
  assign mb_set[slfr_pkg::MB_SLV_ERR_BIT] = |slv_ev;           // RULE7
  assign mb_set[slfr_pkg::MB_CANCEL_BIT]  = |cancel_ev;        // RULE8
  assign mb_set[slfr_pkg::MB_PAR_LO_BIT]  = par_err_i[0];      // RULE9
  assign mb_set[slfr_pkg::MB_PAR_HI_BIT]  = par_err_i[1];      // RULE9
  assign mb_set[7:5] = 3'b000;

  // the group field keeps the first faulting slave until software clears
  // the word; a later slave would otherwise hide the root cause
  wire [4:0] grp_code = slv_group_i + 5'h01;                   // RULE10
  wire       grp_free = (sbyte_r[slfr_pkg::SB_GROUP_W-1:0] == 5'h00);

  wire [7:0] sb_set;
  assign sb_set[4:0] = (|slv_ev && grp_free) ? grp_code : 5'h00;
  assign sb_set[slfr_pkg::SB_BAD_BIT] =
         |slv_ev & slv_kind_i[slfr_pkg::KIND_BAD];             // RULE11
  assign sb_set[slfr_pkg::SB_OTHER_BIT] =
         |slv_ev & slv_kind_i[slfr_pkg::KIND_OTHER];           // RULE12
  assign sb_set[slfr_pkg::SB_WDT_PAR_BIT] =
         |slv_ev & slv_kind_i[slfr_pkg::KIND_WDTP];            // RULE13

  wire seq_ev = link_ev | (|par_err_i);

  // a clear write loses to a same-cycle event, but a new slave group is dropped if a group was already held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mbyte_r <= 8'h00;
      sbyte_r <= 8'h00;
      fch_r   <= 2'b00;
      sub_r   <= 1'b0;
    end else begin
      mbyte_r <= (wr_fault ? 8'h00 : mbyte_r) | mb_set;
      sbyte_r <= (wr_fault ? 8'h00 : sbyte_r) | sb_set;
      fch_r   <= (wr_fault ? 2'b00 : fch_r) | ch_ev;           // RULE5
      sub_r   <= (wr_fault ? 1'b0 : sub_r) | link_ev;          // RULE4
    end
  end

  // ----------------------------------------------------------------------
  // watchdog of the sequence controller
  // ----------------------------------------------------------------------
  // the watchdog sleeps while the link is disabled, so a hung controller
  // is only reported once software has turned the block on; it fires
  // once and waits for a kick or a disable before it can fire again
  wire wdt_ev = en_r & ~wdt_kick_i & ~wdt_hit_r &
                (wdt_cnt_r >= 32'(WDT_LIM - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_r || wdt_kick_i) begin
      wdt_cnt_r <= 32'h0000_0000;
      wdt_hit_r <= 1'b0;
    end else if (wdt_ev) begin
      wdt_hit_r <= 1'b1;                                       // RULE14
    end else if (!wdt_hit_r) begin
      wdt_cnt_r <= wdt_cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // alarm selection and interrupt status
  // ----------------------------------------------------------------------
  wire [5:0] ev;
  assign ev[slfr_pkg::SLFR_EV_LINK] = seq_ev;                  // RULE4
  assign ev[slfr_pkg::SLFR_EV_WDT]  = wdt_ev;                  // RULE14
  assign ev[slfr_pkg::SLFR_EV_OPT]  = opt_err_i;               // RULE15
  assign ev[slfr_pkg::SLFR_EV_FBUS] = fbus_err_i;              // RULE16
  assign ev[slfr_pkg::SLFR_EV_MBUS] = mbus_err_i;              // RULE17
  assign ev[slfr_pkg::SLFR_EV_LBUS] = lbus_err_i;              // RULE18

  // the lowest event index wins when several arrive together
  wire [9:0] alarm_nxt =
      ev[slfr_pkg::SLFR_EV_LINK] ? slfr_pkg::ALM_SEQ  :
      ev[slfr_pkg::SLFR_EV_WDT]  ? slfr_pkg::ALM_WDT  :
      ev[slfr_pkg::SLFR_EV_OPT]  ? slfr_pkg::ALM_OPT  :
      ev[slfr_pkg::SLFR_EV_FBUS] ? slfr_pkg::ALM_FBUS :
      ev[slfr_pkg::SLFR_EV_MBUS] ? slfr_pkg::ALM_MBUS :
      ev[slfr_pkg::SLFR_EV_LBUS] ? slfr_pkg::ALM_LBUS :
                                   slfr_pkg::ALM_NONE;

  // the first alarm is kept until software clears it; later ones only
  // show in the status bits, which keeps the root cause visible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r   <= slfr_pkg::ALM_NONE;
      alarm_v_r <= 1'b0;
      slot_r    <= 8'h00;
    end else if ((!alarm_v_r || wr_alarm) && |ev) begin
      alarm_r   <= alarm_nxt;
      alarm_v_r <= 1'b1;
      slot_r    <= opt_err_i ? opt_slot_i : 8'h00;             // RULE15
    end else if (wr_alarm) begin
      alarm_r   <= slfr_pkg::ALM_NONE;
      alarm_v_r <= 1'b0;
      slot_r    <= 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_r <= 6'h00;
      irq_r   <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~iclr) | ev;
      irq_r   <= |(((istat_r & ~iclr) | ev) & imask_r);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  logic master_r;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      master_r <= 1'b1;                                        // RULE3
    else
      master_r <= 1'b1;                                        // RULE3
  end

  assign wb_dat_o             = dat_r;
  assign wb_ack_o             = ack_r;
  assign int_o                = irq_r;
  assign link_master_o        = master_r;
  assign tx_frame_o           = tx_frame_r;
  assign tx_state_o           = tx_out_r;
  assign alarm_valid_o        = alarm_v_r;
  assign alarm_code_o         = alarm_r;
  assign link_fault_subcode_o = sub_r;
  assign fault_word_o         = {mbyte_r, sbyte_r};            // RULE19
  assign fault_ch_o           = fch_r;
  assign opt_slot_o           = slot_r;

endmodule

// [sim/slfr_props.sv]
// assertion checker on the fault reporter ports
`timescale 1ns/1ps
module slfr_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic        link_master_o,
  input wire logic        tx_frame_o,
  input wire logic [1:0]  rx_bad_i,
  input wire logic [1:0]  slv_err_i,
  input wire logic [4:0]  slv_group_i,
  input wire logic [2:0]  slv_kind_i,
  input wire logic [1:0]  par_err_i,
  input wire logic        opt_err_i,
  input wire logic [7:0]  opt_slot_i,
  input wire logic        fbus_err_i,
  input wire logic        mbus_err_i,
  input wire logic        lbus_err_i,
  input wire logic        alarm_valid_o,
  input wire logic [9:0]  alarm_code_o,
  input wire logic        link_fault_subcode_o,
  input wire logic [15:0] fault_word_o,
  input wire logic [1:0]  fault_ch_o,
  input wire logic [7:0]  opt_slot_o
);
  // ----
  // shadow of the enable bit, tracked from bus writes
  // ----
  logic en_r;
  logic en_nxt;
  wire  ctl_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
                 & (wb_adr_i[7:2] == 6'h00) & wb_sel_i[0];
  // calm: no link logic, no watchdog, no held alarm
  wire  calm = ~en_r & ~alarm_valid_o & ~(|par_err_i);
  wire [9:0] bus_code = fbus_err_i ? 10'h3ce : mbus_err_i ? 10'h3cf
                      : 10'h3d0;
  assign en_nxt = ctl_wr ? wb_dat_i[0] : en_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) en_r <= 1'b0;
    else en_r <= en_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_slv_code;
    fault_word_o[9] && alarm_valid_o
    && fault_word_o[4:0] == $past(slv_group_i) + 5'h01
    && (fault_word_o[7:5] & $past(slv_kind_i)) == $past(slv_kind_i);
  endsequence
  a_ack_pulse:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack)
    else $error("bus answer is not a single cycle ack");
  a_master_role:
    assert property (link_master_o)
    else $error("block left the link master role");
  a_tx_idle:
    assert property (!en_r |=> !tx_frame_o)
    else $error("output frame sent while disabled");
  a_rx_bad_bit:
    assert property (en_r && rx_bad_i != 2'h0 |=> fault_word_o[8]
      && link_fault_subcode_o
      && (fault_ch_o & $past(rx_bad_i)) == $past(rx_bad_i))
    else $error("bad receive not reported");
  a_slave_code:
    assert property (en_r && slv_err_i != 2'h0
      && fault_word_o[4:0] == 5'h00 |=> s_slv_code)
    else $error("slave error byte wrong");
  a_parity_bits:
    assert property (par_err_i != 2'h0 |=> alarm_valid_o
      && (fault_word_o[12:11] & $past(par_err_i)) == $past(par_err_i))
    else $error("parity error not reported");
  a_opt_alarm:
    assert property (calm && opt_err_i |=> alarm_code_o == 10'h3cc
      && opt_slot_o == $past(opt_slot_i))
    else $error("option board alarm wrong");
  a_bus_alarm:
    assert property (calm && !opt_err_i
      && (fbus_err_i || mbus_err_i || lbus_err_i)
      |=> alarm_code_o == $past(bus_code))
    else $error("bus error alarm wrong");
endmodule

// [sim/slfr_slave_model.sv]
// slave devices: periodic input frames on both channels
`timescale 1ns/1ps
module slfr_slave_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  mute_i,
  output logic      [1:0]  rx_valid_o,
  output logic      [31:0] rx_state_o
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end
  // a frame every 8 cycles; a muted channel looks unplugged
  assign rx_valid_o = (cnt_r[2:0] == 3'h0) ? ~mute_i : 2'h0;
  // between frames the lines toggle so stale data is never valid
  assign rx_state_o = (|rx_valid_o) ? {24'h5a5a5a, cnt_r}
                    : {4{~cnt_r}};
endmodule

// [sim/slfr_top_tb.sv]
// self-checking bench for the serial link fault reporter
`timescale 1ns/1ps
module slfr_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o, tx_state_o, rx_state_i;
  logic        wb_ack_o, int_o, link_master_o, tx_frame_o;
  logic [1:0]  rx_valid_i, mute = 2'h0, fault_ch_o;
  logic [1:0]  rx_bad_i = 2'h0, slv_err_i = 2'h0, par_err_i = 2'h0;
  logic [4:0]  slv_group_i = 5'h00;
  logic [2:0]  slv_kind_i = 3'h0;
  logic        wdt_kick_i = 1'b0, kick_on = 1'b0;
  logic [3:0]  board = 4'h0;
  logic        opt_err_i, fbus_err_i, mbus_err_i, lbus_err_i;
  logic [7:0]  opt_slot_i = 8'h07, opt_slot_o;
  logic        alarm_valid_o, link_fault_subcode_o;
  logic [9:0]  alarm_code_o;
  logic [15:0] fault_word_o;
  logic [31:0] q;
  int          errors = 0, n_checks = 0, n;
  logic [31:0] codes [4] = '{32'h3cc, 32'h3ce, 32'h3cf, 32'h3d0};
  logic [4:0]  grp [3] = '{5'h00, 5'h0e, 5'h01};
  logic [31:0] slv [3] = '{32'h0221, 32'h024f, 32'h0282};
  assign {lbus_err_i, mbus_err_i, fbus_err_i, opt_err_i} = board;
  slfr_top #(.CANCEL_LIM(20), .WDT_LIM(40)) u_slfr_top (.*);
  slfr_slave_model u_slfr_slave_model (.clk_i(clk_i), .rst_i(rst_i),
    .mute_i(mute), .rx_valid_o(rx_valid_i), .rx_state_o(rx_state_i));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) wdt_kick_i <= kick_on;
  // ----
  // bus and event tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) chk(32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic clr;
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h18, 32'h3f);
  endtask
  task automatic fire(input logic [3:0] b, input logic [1:0] p,
                      input logic [1:0] s, input logic [1:0] r);
    @(posedge clk_i);
    board <= b;
    par_err_i <= p;
    slv_err_i <= s;
    rx_bad_i <= r;
    @(posedge clk_i);
    board <= 4'h0;
    par_err_i <= 2'h0;
    slv_err_i <= 2'h0;
    rx_bad_i <= 2'h0;
    @(posedge clk_i);
  endtask
  // waits for a frame (0), a cancel (1) or an alarm (2)
  task automatic wt(input int s);
    logic hit;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      hit = s == 0 ? tx_frame_o : s == 1 ? fault_word_o[10]
          : alarm_valid_o;
    end while (hit !== 1'b1 && n < 80);
    if (hit !== 1'b1) chk(32'h0, 32'h1);
  endtask
  task automatic complete_run;
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'(link_master_o), 32'h1);
    rd(8'h04, 32'h32);
    rd(8'h20, 32'h0);
    wb(1'b1, 8'h1c, 32'h3f);
    for (int i = 0; i < 4; i++) begin
      clr();
      fire(4'h1 << i, 2'h0, 2'h0, 2'h0);
      chk(32'(alarm_code_o), codes[i]);
      chk(32'(int_o), 32'h1);
    end
    wb(1'b1, 8'h1c, 32'h3b);
    clr();
    fire(4'h1, 2'h0, 2'h0, 2'h0);
    chk(32'(int_o), 32'h0);
    rd(8'h18, 32'h4);
    rd(8'h14, 32'h000707cc);
    chk(32'(opt_slot_o), 32'h7);
    wb(1'b1, 8'h1c, 32'h3f);
    @(posedge clk_i);
    chk(32'(int_o), 32'h1);
    wb(1'b1, 8'h18, 32'h4);
    @(posedge clk_i);
    chk(32'(int_o), 32'h0);
    // link faults are refused while disabled, parity is not
    clr();
    fire(4'h0, 2'h0, 2'h1, 2'h1);
    chk(32'(fault_word_o), 32'h0);
    fire(4'h0, 2'h1, 2'h0, 2'h0);
    chk(32'(fault_word_o), 32'h0800);
    chk(32'(alarm_code_o), 32'h3b6);
    chk(32'(link_fault_subcode_o), 32'h0);
    clr();
    fire(4'h0, 2'h2, 2'h0, 2'h0);
    chk(32'(fault_word_o), 32'h1000);
    kick_on <= 1'b1;
    wb(1'b1, 8'h04, 32'h4);
    wb(1'b1, 8'h08, 32'h5a3c96e1);
    wb(1'b1, 8'h00, 32'h1);
    wt(0);
    chk(tx_state_o, 32'h5a3c96e1);
    wt(0);
    chk(32'(n), 32'h4);
    wb(1'b0, 8'h0c, 32'h0);
    chk(32'(q[31:8]), 32'h5a5a5a);
    for (int k = 0; k < 3; k++) begin
      clr();
      slv_group_i <= grp[k];
      slv_kind_i <= 3'h1 << k;
      fire(4'h0, 2'h0, 2'h1 << k[0], 2'h0);
      chk(32'(fault_word_o), slv[k]);
      chk(32'(fault_ch_o), 32'h1 << k[0]);
      chk(32'(link_fault_subcode_o), 32'h1);
    end
    clr();
    fire(4'h0, 2'h0, 2'h0, 2'h2);
    chk(32'(fault_word_o), 32'h0100);
    chk(32'(fault_ch_o), 32'h2);
    clr();
    mute <= 2'h2;
    wt(1);
    chk(32'(fault_word_o), 32'h0400);
    chk(32'(fault_ch_o), 32'h2);
    mute <= 2'h0;
    clr();
    kick_on <= 1'b0;
    wt(2);
    chk(32'(alarm_code_o), 32'h3b7);
    complete_run();
  end
endmodule
bind slfr_top slfr_props u_slfr_props (.*);
